// *** pkg/status_command_pkg.sv ***
// status_command_pkg: constants, command codes and carrier types of the status command unit
// assumes commands arrive already parsed, one decoded opcode and one integer argument each
package status_command_pkg;

  // ***************************************************
  // status byte and standard event bit positions
  // ***************************************************
  localparam int STB_EAV_BIT = 2;
  localparam int STB_QSB_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_OSB_BIT = 7;
  localparam int STANDARD_EVENT_FLAGS_OPC_BIT = 0;
  localparam int STANDARD_EVENT_FLAGS_EXE_BIT = 4;

  // ***************************************************
  // ranges, replies and defaults
  // ***************************************************
  localparam logic [15:0] BYTE_MAX = 16'h00FF;
  localparam logic [15:0] LOC_MAX = 16'h0063;
  localparam int MEM_LOCS = 100;
  localparam int OUTQ_DEPTH = 8;
  localparam int ERRQ_DEPTH = 4;
  localparam logic [15:0] OPC_REPLY = 16'h0001;
  localparam logic signed [15:0] TST_PASS = 16'sh0000;
  localparam logic signed [15:0] TST_FAIL = -16'sh012C;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] PRESET_ENABLE = 16'h0000;
  localparam logic [6:0] AUTO_START_DEF = 7'h00;
  localparam logic [6:0] AUTO_END_DEF = 7'h05;
  localparam logic [15:0] AUTO_CYCLE_DEF = 16'h0001;
  localparam logic [15:0] AUTO_DELAY_S_DEF = 16'h0001;
  localparam logic [15:0] OVP_MAX = 16'hFFFF;
  localparam longint CLK_HZ = 40000000;
  localparam longint SEC_S = 1;
  localparam int SEC_CYCLES = int'(CLK_HZ * SEC_S);

  typedef enum logic [5:0] {
    OP_CLS, OP_ESE_SET, OP_ESE_GET, OP_ESR_GET, OP_SRE_SET, OP_SRE_GET, OP_STB_GET,
    OP_OPER_COND, OP_OPER_EN_SET, OP_OPER_EN_GET, OP_OPER_EVT, OP_PRESET,
    OP_QUES_COND, OP_QUES_EN_SET, OP_QUES_EN_GET, OP_QUES_EVT,
    OP_IDN, OP_OPC, OP_OPC_Q, OP_RCL, OP_SAV, OP_RST, OP_TST, OP_WAI,
    OP_CYC_SET, OP_CYC_GET, OP_DLY_SET, OP_DLY_GET, OP_END_SET, OP_END_GET,
    OP_START_SET, OP_START_GET, OP_AUTO_SET, OP_AUTO_GET, OP_ERR_GET, OP_MEM_GET
  } op_type;

  typedef struct packed {
    op_type op;
    logic [15:0] arg;
  } cmd_type;

  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] ovp;
    logic ocp_on;
    logic out_on;
    logic [1:0] track;
  } setting_type;

  localparam setting_type SETTING_DEF = '{16'h0000, 16'h0000, OVP_MAX, 1'b0, 1'b0, 2'h0};

endpackage

// *** logic/status_command_unit.sv ***
// status_command_unit: event structure, queues and housekeeping commands of a bench supply
// assumes a parser upstream handing decoded commands and a formatter draining integer replies
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - clear-status empties output queue, zeroes event registers
// - summary bit 5 is masked standard events
// - event mask 0..255 set, read back
// - event flags query returns then clears
// - operation-complete sets flag bit 0 when idle
// - completion query queues 1, no flag set
// - recall location 0..99 restores saved settings
// - commands run strictly one after another
// - reset restores defaults, output off, section 00
// - preset puts operation/questionable groups preset
// - operation and questionable enable masks read/write
// - condition and event registers readable by query
// - error query pops oldest queue entry
// - identification returns maker, model, serial, firmware
// - self-test query runs test, queues result
// - auto sequence start, end, repeat, delay, state
// - service request mask written and read back
// - status byte query leaves contents unchanged
// - service request mask bit 6 reads zero
// - self-test replies 0 pass, -300 fail
module status_command_unit
  import status_command_pkg::*;
#(
  parameter logic [15:0] ID_MAKER = 16'h0A01,   // arbitrary
  parameter logic [15:0] ID_MODEL = 16'h0B02,   // arbitrary
  parameter logic [15:0] ID_SERIAL = 16'h0C03,  // arbitrary
  parameter logic [15:0] ID_FW = 16'h0D04,      // arbitrary
  parameter int TICKS_PER_SEC = SEC_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire cmd_type cmd_i,
  output logic cmd_ready_o,
  output logic resp_valid_o,
  output logic [15:0] resp_o,
  input wire logic resp_ready_i,
  input wire logic busy_i,
  input wire logic [7:0] event_set_i,
  input wire logic [15:0] oper_cond_i,
  input wire logic [15:0] ques_cond_i,
  input wire logic err_push_i,
  input wire logic [15:0] err_code_i,
  output logic test_start_o,
  input wire logic test_done_i,
  input wire logic test_fail_i,
  input wire setting_type setting_i,
  output setting_type setting_o,
  output logic setting_load_o,
  output logic srq_o
);

  typedef enum logic [2:0] {ST_IDLE, ST_IDN, ST_OPC, ST_OPCQ, ST_TEST} state_type;

  function automatic logic [15:0] byte16(input logic [7:0] b);
    byte16 = {8'h00, b};
  endfunction

  function automatic logic [15:0] loc16(input logic [6:0] l);
    loc16 = {9'h000, l};
  endfunction

  state_type state_q;
  logic [1:0] idn_idx_q;
  logic [7:0] ese_q, esr_q, sre_q;
  logic [15:0] oper_en_q, oper_evt_q, oper_prev_q;
  logic [15:0] ques_en_q, ques_evt_q, ques_prev_q;
  logic [15:0] outq_mem [OUTQ_DEPTH];
  logic [2:0] outq_rd_q, outq_wr_q;
  logic [3:0] outq_cnt_q;
  logic [15:0] errq_mem [ERRQ_DEPTH];
  logic [1:0] errq_rd_q, errq_wr_q;
  logic [2:0] errq_cnt_q;
  setting_type mem_q [MEM_LOCS];
  logic [6:0] mem_sel_q;
  logic [6:0] auto_start_q, auto_end_q, auto_loc_q;
  logic [15:0] auto_cyc_q, auto_dly_q, auto_left_q, dly_cnt_q;
  logic auto_on_q;
  logic [31:0] sec_cnt_q;
  logic sec_tick, auto_step;
  logic take, push, pop, err_pop, arg_byte_ok, arg_loc_ok, esr_read;
  logic [15:0] push_val;
  logic [7:0] stb;

  // ***************************************************
  // summary byte and service request
  // ***************************************************
  always_comb begin
    stb = 8'h00;
    stb[STB_EAV_BIT] = (errq_cnt_q != 3'h0);
    stb[STB_QSB_BIT] = |(ques_evt_q & ques_en_q);
    stb[STB_MAV_BIT] = (outq_cnt_q != 4'h0);
    stb[STB_ESB_BIT] = |(esr_q & ese_q);
    stb[STB_OSB_BIT] = |(oper_evt_q & oper_en_q);
    stb[STB_RQS_BIT] = |(stb & sre_q);
  end

  assign srq_o = stb[STB_RQS_BIT];

  // ***************************************************
  // command acceptance and reply selection
  // ***************************************************
  // a command is taken only when idle with room for the widest reply
  assign cmd_ready_o = (state_q == ST_IDLE) && (outq_cnt_q <= 4'(OUTQ_DEPTH - 4));
  assign take = cmd_valid_i && cmd_ready_o;
  assign arg_byte_ok = (cmd_i.arg <= BYTE_MAX);
  assign arg_loc_ok = (cmd_i.arg <= LOC_MAX);
  assign esr_read = take && (cmd_i.op == OP_ESR_GET);
  assign err_pop = take && (cmd_i.op == OP_ERR_GET) && (errq_cnt_q != 3'h0);

  always_comb begin
    push = 1'b0;
    push_val = 16'h0000;
    if (state_q == ST_IDN) begin
      push = 1'b1;
      unique case (idn_idx_q)
        2'h0: push_val = ID_MAKER;
        2'h1: push_val = ID_MODEL;
        2'h2: push_val = ID_SERIAL;
        2'h3: push_val = ID_FW;
      endcase
    end else if (state_q == ST_OPCQ) begin
      push = !busy_i;
      push_val = OPC_REPLY;
    end else if (state_q == ST_TEST) begin
      push = test_done_i;
      push_val = test_fail_i ? TST_FAIL : TST_PASS;
    end else if (take) begin
      push = 1'b1;
      unique case (cmd_i.op)
        OP_ESE_GET: push_val = byte16(ese_q);
        OP_ESR_GET: push_val = byte16(esr_q);
        OP_SRE_GET: push_val = byte16(sre_q);
        OP_STB_GET: push_val = byte16(stb);
        OP_OPER_COND: push_val = oper_cond_i;
        OP_OPER_EN_GET: push_val = oper_en_q;
        OP_OPER_EVT: push_val = oper_evt_q;
        OP_QUES_COND: push_val = ques_cond_i;
        OP_QUES_EN_GET: push_val = ques_en_q;
        OP_QUES_EVT: push_val = ques_evt_q;
        OP_CYC_GET: push_val = auto_cyc_q;
        OP_DLY_GET: push_val = auto_dly_q;
        OP_END_GET: push_val = loc16(auto_end_q);
        OP_START_GET: push_val = loc16(auto_start_q);
        OP_AUTO_GET: push_val = {15'h0000, auto_on_q};
        OP_MEM_GET: push_val = loc16(mem_sel_q);
        OP_ERR_GET: push_val = (errq_cnt_q != 3'h0) ? errq_mem[errq_rd_q] : ERR_NONE;
        default: push = 1'b0;
      endcase
    end
  end

  // ***************************************************
  // sequencer for replies that wait or span cycles
  // ***************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      idn_idx_q <= 2'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          idn_idx_q <= 2'h0;
          if (take) begin
            unique case (cmd_i.op)
              OP_IDN: state_q <= ST_IDN;
              OP_OPC: state_q <= ST_OPC;
              OP_OPC_Q: state_q <= ST_OPCQ;
              OP_TST: state_q <= ST_TEST;
              default: state_q <= ST_IDLE;
            endcase
          end
        end
        ST_IDN: begin
          idn_idx_q <= idn_idx_q + 2'h1;
          if (idn_idx_q == 2'h3) begin
            state_q <= ST_IDLE;
          end
        end
        ST_OPC, ST_OPCQ: begin
          if (!busy_i) begin
            state_q <= ST_IDLE;
          end
        end
        ST_TEST: begin
          if (test_done_i) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign test_start_o = take && (cmd_i.op == OP_TST);

  // ***************************************************
  // output queue
  // ***************************************************
  assign resp_valid_o = (outq_cnt_q != 4'h0);
  assign resp_o = outq_mem[outq_rd_q];
  assign pop = resp_valid_o && resp_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      outq_mem[outq_wr_q] <= push_val;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      outq_rd_q <= 3'h0;
      outq_wr_q <= 3'h0;
      outq_cnt_q <= 4'h0;
    end else if (take && cmd_i.op == OP_CLS) begin
      outq_rd_q <= 3'h0;
      outq_wr_q <= 3'h0;
      outq_cnt_q <= 4'h0;
    end else begin
      outq_rd_q <= outq_rd_q + 3'(pop);
      outq_wr_q <= outq_wr_q + 3'(push);
      outq_cnt_q <= outq_cnt_q + 4'(push) - 4'(pop);
    end
  end

  // ***************************************************
  // error and event queue
  // ***************************************************
  // an entry arriving while full is lost; oldest entries are kept
  always_ff @(posedge clock_i) begin
    if (err_push_i && errq_cnt_q != 3'(ERRQ_DEPTH)) begin
      errq_mem[errq_wr_q] <= err_code_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      errq_rd_q <= 2'h0;
      errq_wr_q <= 2'h0;
      errq_cnt_q <= 3'h0;
    end else begin
      errq_rd_q <= errq_rd_q + 2'(err_pop);
      errq_wr_q <= errq_wr_q + 2'(err_push_i && errq_cnt_q != 3'(ERRQ_DEPTH));
      errq_cnt_q <= errq_cnt_q + 3'(err_push_i && errq_cnt_q != 3'(ERRQ_DEPTH)) - 3'(err_pop);
    end
  end

  // ***************************************************
  // standard event flags and masks
  // ***************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      esr_q <= 8'h00;
    end else begin
      // new events win over a clearing read in the same cycle
      esr_q <= ((esr_read || (take && cmd_i.op == OP_CLS)) ? 8'h00 : esr_q)
        | event_set_i
        | ((state_q == ST_OPC && !busy_i) ? 8'(1 << STANDARD_EVENT_FLAGS_OPC_BIT) : 8'h00)
        | ((take && !arg_byte_ok && (cmd_i.op == OP_ESE_SET || cmd_i.op == OP_SRE_SET))
           ? 8'(1 << STANDARD_EVENT_FLAGS_EXE_BIT) : 8'h00)
        | ((take && !arg_loc_ok && (cmd_i.op == OP_RCL || cmd_i.op == OP_SAV))
           ? 8'(1 << STANDARD_EVENT_FLAGS_EXE_BIT) : 8'h00);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ese_q <= 8'h00;
      sre_q <= 8'h00;
    end else if (take && arg_byte_ok) begin
      if (cmd_i.op == OP_ESE_SET) begin
        ese_q <= cmd_i.arg[7:0];
      end
      if (cmd_i.op == OP_SRE_SET) begin
        sre_q <= cmd_i.arg[7:0] & ~8'(1 << STB_RQS_BIT);
      end
    end
  end

  // ***************************************************
  // operation and questionable groups
  // ***************************************************
  // events latch rising condition edges; conditions come from logic on this clock
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oper_prev_q <= 16'h0000;
      ques_prev_q <= 16'h0000;
      oper_evt_q <= 16'h0000;
      ques_evt_q <= 16'h0000;
    end else begin
      oper_prev_q <= oper_cond_i;
      ques_prev_q <= ques_cond_i;
      oper_evt_q <= ((take && (cmd_i.op == OP_CLS || cmd_i.op == OP_OPER_EVT)) ? 16'h0000
        : oper_evt_q) | (oper_cond_i & ~oper_prev_q);
      ques_evt_q <= ((take && (cmd_i.op == OP_CLS || cmd_i.op == OP_QUES_EVT)) ? 16'h0000
        : ques_evt_q) | (ques_cond_i & ~ques_prev_q);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oper_en_q <= ENABLE_RESET;
      ques_en_q <= ENABLE_RESET;
    end else if (take) begin
      unique case (cmd_i.op)
        OP_OPER_EN_SET: oper_en_q <= cmd_i.arg;
        OP_QUES_EN_SET: ques_en_q <= cmd_i.arg;
        OP_PRESET: begin
          oper_en_q <= PRESET_ENABLE;
          ques_en_q <= PRESET_ENABLE;
        end
        default: begin
          oper_en_q <= oper_en_q;
          ques_en_q <= ques_en_q;
        end
      endcase
    end
  end

  // ***************************************************
  // setting memory, recall and reset defaults
  // ***************************************************
  always_ff @(posedge clock_i) begin
    if (take && cmd_i.op == OP_SAV && arg_loc_ok) begin
      mem_q[cmd_i.arg[6:0]] <= setting_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      setting_o <= SETTING_DEF;
      setting_load_o <= 1'b0;
      mem_sel_q <= 7'h00;
    end else begin
      setting_load_o <= 1'b0;
      if (take && cmd_i.op == OP_RST) begin
        setting_o <= SETTING_DEF;
        setting_load_o <= 1'b1;
        mem_sel_q <= 7'h00;
      end else if (take && cmd_i.op == OP_RCL && arg_loc_ok) begin
        setting_o <= mem_q[cmd_i.arg[6:0]];
        setting_load_o <= 1'b1;
        mem_sel_q <= cmd_i.arg[6:0];
      end else if (auto_step) begin
        setting_o <= mem_q[auto_loc_q];
        setting_load_o <= 1'b1;
        mem_sel_q <= auto_loc_q;
      end
    end
  end

  // ***************************************************
  // auto sequence
  // ***************************************************
  assign sec_tick = auto_on_q && (sec_cnt_q == 32'(TICKS_PER_SEC - 1));
  assign auto_step = sec_tick && (dly_cnt_q + 16'h0001 >= auto_dly_q);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_cnt_q <= 32'h0000_0000;
      dly_cnt_q <= 16'h0000;
    end else if (!auto_on_q || sec_tick) begin
      sec_cnt_q <= 32'h0000_0000;
      dly_cnt_q <= (!auto_on_q || auto_step) ? 16'h0000 : dly_cnt_q + 16'h0001;
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auto_start_q <= AUTO_START_DEF;
      auto_end_q <= AUTO_END_DEF;
      auto_cyc_q <= AUTO_CYCLE_DEF;
      auto_dly_q <= AUTO_DELAY_S_DEF;
      auto_on_q <= 1'b0;
      auto_loc_q <= AUTO_START_DEF;
      auto_left_q <= AUTO_CYCLE_DEF;
    end else if (take && cmd_i.op == OP_RST) begin
      auto_start_q <= AUTO_START_DEF;
      auto_end_q <= AUTO_END_DEF;
      auto_cyc_q <= AUTO_CYCLE_DEF;
      auto_dly_q <= AUTO_DELAY_S_DEF;
      auto_on_q <= 1'b0;
    end else if (take) begin
      unique case (cmd_i.op)
        OP_START_SET: if (arg_loc_ok) auto_start_q <= cmd_i.arg[6:0];
        OP_END_SET: if (arg_loc_ok) auto_end_q <= cmd_i.arg[6:0];
        OP_CYC_SET: auto_cyc_q <= cmd_i.arg;
        OP_DLY_SET: auto_dly_q <= cmd_i.arg;
        OP_AUTO_SET: begin
          auto_on_q <= cmd_i.arg[0];
          auto_loc_q <= auto_start_q;
          auto_left_q <= auto_cyc_q;
        end
        default: auto_on_q <= auto_on_q;
      endcase
    end else if (auto_step) begin
      // a full pass from start to end uses up one cycle; zero cycles wraps the count and stops after 65536 passes
      if (auto_loc_q == auto_end_q) begin
        auto_loc_q <= auto_start_q;
        auto_left_q <= auto_left_q - 16'h0001;
        if (auto_left_q == 16'h0001) begin
          auto_on_q <= 1'b0;
        end
      end else begin
        auto_loc_q <= auto_loc_q + 7'h01;
      end
    end
  end

endmodule

`default_nettype wire

// *** tb/status_command_chk.sv ***
// status_command_chk: port assertions for the status command unit
// assumes one clock domain, attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module status_command_chk
  import status_command_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire cmd_type cmd_i,
  input wire logic cmd_ready_o,
  input wire logic resp_valid_o,
  input wire logic [15:0] resp_o,
  input wire logic resp_ready_i,
  input wire logic busy_i,
  input wire logic test_start_o,
  input wire logic test_done_i,
  input wire setting_type setting_o,
  input wire logic setting_load_o,
  input wire logic srq_o
);
  // ****
  // helper state
  // ****
  logic take;
  logic tst_wait_q;
  assign take = cmd_valid_i && cmd_ready_o;
  // a done pulse only counts while a test is outstanding
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tst_wait_q <= 1'b0;
    end else if (test_start_o) begin
      tst_wait_q <= 1'b1;
    end else if (test_done_i) begin
      tst_wait_q <= 1'b0;
    end
  end
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // ****
  // assertions
  // ****
  chk_clear_empties: assert property (take && cmd_i.op == OP_CLS |=> !resp_valid_o)
    else $error("queue not empty after clear");
  chk_query_answers: assert property (take && cmd_i.op inside {OP_ESE_GET, OP_ESR_GET,
    OP_SRE_GET, OP_STB_GET} |=> resp_valid_o)
    else $error("query gave no reply");
  chk_opcq_reply: assert property ((take && cmd_i.op == OP_OPC_Q) ##1 !busy_i |=> resp_valid_o)
    else $error("completion query gave no reply");
  chk_wait_holds: assert property ((take && cmd_i.op inside {OP_OPC, OP_OPC_Q}) ##1 busy_i
    |=> !cmd_ready_o)
    else $error("command taken while waiting");
  chk_reset_output: assert property (take && cmd_i.op == OP_RST |=> setting_o.out_on == 1'b0
    && setting_o.volt == 16'h0000 && setting_o.curr == 16'h0000)
    else $error("reset left output set");
  chk_recall_loads: assert property (take && cmd_i.op == OP_RCL && cmd_i.arg <= LOC_MAX
    |-> ##[1:2] setting_load_o)
    else $error("recall did not load");
  chk_reply_holds: assert property (resp_valid_o && !resp_ready_i && !(take && cmd_i.op == OP_CLS)
    |=> resp_valid_o && $stable(resp_o))
    else $error("reply lost before pop");
  chk_tst_take: assert property (test_start_o |=> !cmd_ready_o)
    else $error("command accepted during self-test");
  chk_tst_reply: assert property (tst_wait_q && test_done_i |=> resp_valid_o)
    else $error("self-test gave no reply");
  cover property (take && cmd_i.op == OP_ESR_GET);
  cover property (setting_load_o);
  cover property (srq_o);
endmodule

bind status_command_unit status_command_chk i_status_command_chk (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
  .resp_valid_o(resp_valid_o), .resp_o(resp_o), .resp_ready_i(resp_ready_i), .busy_i(busy_i),
  .test_start_o(test_start_o), .test_done_i(test_done_i), .setting_o(setting_o),
  .setting_load_o(setting_load_o), .srq_o(srq_o));
`default_nettype wire

// *** tb/host_model.sv ***
// host_model: controller side that drains replies at a chosen pace
// assumes pace 0 prompt, 1 one pop in four cycles, 2 stalled
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [1:0] pace_i,
  output logic resp_ready_o
);
  logic [1:0] tick_q;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= 2'h0;
      resp_ready_o <= 1'b0;
    end else begin
      tick_q <= tick_q + 2'h1;
      resp_ready_o <= (pace_i == 2'h0) || (pace_i == 2'h1 && tick_q == 2'h3);
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// tb: self-checking bench for the status command unit
// assumes host_model draining replies and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb;
  import status_command_pkg::*;
  localparam logic [15:0] ID_W[4] = '{16'h1A2B, 16'h3C4D, 16'h5E6F, 16'h7081}; // arbitrary
  localparam op_type G_OP[7] = '{OP_OPER_EN_GET, OP_QUES_EN_GET, OP_OPER_COND, OP_QUES_COND,
    OP_OPER_EVT, OP_OPER_EVT, OP_QUES_EVT};
  localparam logic [15:0] G_EXP[7] = '{16'h5, 16'h9, 16'h3, 16'h108, 16'h3, 16'h0, 16'h108};
  localparam op_type D_OP[6] = '{OP_START_GET, OP_END_GET, OP_CYC_GET, OP_DLY_GET,
    OP_AUTO_GET, OP_MEM_GET};
  localparam logic [15:0] D_EXP[6] = '{16'h0, 16'h5, 16'h1, 16'h1, 16'h0, 16'h0};
  logic clock_i, rst_n_i, cmd_valid_i, cmd_ready_o, resp_valid_o, resp_ready_i, busy_i;
  logic err_push_i, test_start_o, test_done_i, test_fail_i, setting_load_o, srq_o;
  logic [7:0] event_set_i;
  logic [15:0] resp_o, err_code_i, oper_cond_i, ques_cond_i, rnd;
  logic [15:0] ecode[3];
  logic [1:0] pace;
  cmd_type cmd_i;
  setting_type setting_i, setting_o, sav_a, sav_b;
  logic [15:0] exp_q[$];
  int errors = 0, checked = 0, cycles = 0, seed;

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  status_command_unit #(.ID_MAKER(ID_W[0]), .ID_MODEL(ID_W[1]), .ID_SERIAL(ID_W[2]),
    .ID_FW(ID_W[3]), .TICKS_PER_SEC(10)) i_status_command_unit (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .resp_valid_o(resp_valid_o), .resp_o(resp_o), .resp_ready_i(resp_ready_i),
    .busy_i(busy_i), .event_set_i(event_set_i), .oper_cond_i(oper_cond_i),
    .ques_cond_i(ques_cond_i), .err_push_i(err_push_i), .err_code_i(err_code_i),
    .test_start_o(test_start_o), .test_done_i(test_done_i), .test_fail_i(test_fail_i),
    .setting_i(setting_i), .setting_o(setting_o), .setting_load_o(setting_load_o),
    .srq_o(srq_o));
  host_model i_host_model (.clock_i(clock_i), .rst_n_i(rst_n_i), .pace_i(pace),
    .resp_ready_o(resp_ready_i));

  // ****
  // tasks
  // ****
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_set(input string what, input setting_type exp, input setting_type got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one idle cycle between commands keeps each strobe a single take
  task automatic send(input op_type op, input logic [15:0] arg);
    @(negedge clock_i);
    while (cmd_ready_o !== 1'b1) begin
      @(negedge clock_i);
    end
    cmd_i = '{op, arg};
    cmd_valid_i = 1'b1;
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
  endtask
  task automatic ask(input op_type op, input logic [15:0] exp);
    exp_q.push_back(exp);
    send(op, 16'h0000);
  endtask
  task automatic drain;
    int n = 0;
    while ((resp_valid_o !== 1'b0 || exp_q.size() != 0) && n < 400) begin
      @(negedge clock_i);
      n++;
    end
  endtask
  task automatic pulse(input logic [7:0] bits);
    @(negedge clock_i);
    event_set_i = bits;
    @(negedge clock_i);
    event_set_i = 8'h00;
  endtask
  task automatic tst(input logic fail, input logic [15:0] exp);
    ask(OP_TST, exp);
    test_fail_i = fail;
    test_done_i = 1'b1;
    @(negedge clock_i);
    test_done_i = 1'b0;
  endtask
  task automatic wait_load;
    int n = 0;
    @(negedge clock_i);
    while (setting_load_o !== 1'b1 && n < 60) begin
      @(negedge clock_i);
      n++;
    end
  endtask

  // ****
  // reply monitor and run limit
  // ****
  always @(posedge clock_i) begin
    if (rst_n_i === 1'b1 && resp_valid_o === 1'b1 && resp_ready_i === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("[FAIL] reply expected none seen %h", resp_o);
      end else begin
        cmp("reply", exp_q.pop_front(), resp_o);
      end
    end
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("[FAIL] cycles expected below 20000 seen %0d", cycles);
      close_out;
    end
  end

  // ****
  // scenarios
  // ****
  initial begin
    seed = 77112;
    rst_n_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = '{OP_CLS, 16'h0000};
    busy_i = 1'b0;
    event_set_i = 8'h00;
    oper_cond_i = 16'h0000;
    ques_cond_i = 16'h0000;
    err_push_i = 1'b0;
    err_code_i = 16'h0000;
    test_done_i = 1'b0;
    test_fail_i = 1'b0;
    setting_i = SETTING_DEF;
    pace = 2'h1;
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    rst_n_i = 1'b1;
    ask(OP_STB_GET, 16'h0000);
    rnd = {8'h00, 8'($random(seed))};
    send(OP_ESE_SET, rnd);
    send(OP_ESE_SET, 16'h0100);
    ask(OP_ESE_GET, rnd);
    send(OP_SRE_SET, 16'h00FF);
    ask(OP_SRE_GET, 16'h00BF);
    ask(OP_ESR_GET, 16'h0010);
    ask(OP_ESR_GET, 16'h0000);
    send(OP_ESE_SET, 16'h0004);
    send(OP_SRE_SET, 16'h0020);
    pulse(8'h02);
    drain;
    ask(OP_STB_GET, 16'h0000);
    drain;
    cmp("srq", 16'h0000, {15'h0000, srq_o});
    pulse(8'h04);
    ask(OP_STB_GET, 16'h0060);
    drain;
    cmp("srq", 16'h0001, {15'h0000, srq_o});
    ask(OP_ESR_GET, 16'h0006);
    drain;
    cmp("srq", 16'h0000, {15'h0000, srq_o});
    $display("summary test done");
    busy_i = 1'b1;
    send(OP_OPC, 16'h0000);
    repeat (3) @(negedge clock_i);
    busy_i = 1'b0;
    ask(OP_ESR_GET, 16'h0001);
    busy_i = 1'b1;
    ask(OP_OPC_Q, OPC_REPLY);
    busy_i = 1'b0;
    send(OP_WAI, 16'h0000);
    ask(OP_ESR_GET, 16'h0000);
    $display("completion test done");
    send(OP_OPER_EN_SET, 16'h0005);
    send(OP_QUES_EN_SET, 16'h0009);
    oper_cond_i = 16'h0003;
    ques_cond_i = 16'h0108;
    foreach (G_OP[i]) ask(G_OP[i], G_EXP[i]);
    send(OP_PRESET, 16'h0000);
    ask(OP_OPER_EN_GET, 16'h0000);
    ask(OP_QUES_EN_GET, 16'h0000);
    drain;
    pace = 2'h2;
    ques_cond_i = 16'h0118;
    pulse(8'h80);
    send(OP_ESE_GET, 16'h0000);
    send(OP_CLS, 16'h0000);
    cmp("reply valid", 16'h0000, {15'h0000, resp_valid_o});
    pace = 2'h0;
    ask(OP_QUES_EVT, 16'h0000);
    ask(OP_ESR_GET, 16'h0000);
    $display("group test done");
    for (int i = 0; i < 3; i++) begin
      @(negedge clock_i);
      ecode[i] = 16'($random(seed));
      err_code_i = ecode[i];
      err_push_i = 1'b1;
    end
    @(negedge clock_i);
    err_push_i = 1'b0;
    foreach (ecode[i]) ask(OP_ERR_GET, ecode[i]);
    ask(OP_ERR_GET, ERR_NONE);
    foreach (ID_W[i]) exp_q.push_back(ID_W[i]);
    send(OP_IDN, 16'h0000);
    tst(1'b0, TST_PASS);
    tst(1'b1, TST_FAIL);
    $display("query test done");
    sav_a = 52'({$random(seed), $random(seed)});
    sav_b = 52'({$random(seed), $random(seed)});
    setting_i = sav_a;
    send(OP_SAV, 16'h0007);
    setting_i = sav_b;
    send(OP_SAV, 16'h0008);
    send(OP_RCL, 16'h0007);
    repeat (2) @(negedge clock_i);
    cmp_set("recall", sav_a, setting_o);
    send(OP_RCL, 16'h0064);
    repeat (2) @(negedge clock_i);
    cmp_set("bad recall", sav_a, setting_o);
    send(OP_RST, 16'h0000);
    repeat (2) @(negedge clock_i);
    cmp_set("reset", SETTING_DEF, setting_o);
    foreach (D_OP[i]) ask(D_OP[i], D_EXP[i]);
    send(OP_START_SET, 16'h0007);
    send(OP_END_SET, 16'h0008);
    ask(OP_START_GET, 16'h0007);
    ask(OP_END_GET, 16'h0008);
    send(OP_CYC_SET, 16'h0003);
    send(OP_DLY_SET, 16'h0002);
    ask(OP_CYC_GET, 16'h0003);
    ask(OP_DLY_GET, 16'h0002);
    send(OP_AUTO_SET, 16'h0001);
    wait_load;
    cmp_set("auto first", sav_a, setting_o);
    wait_load;
    cmp_set("auto second", sav_b, setting_o);
    send(OP_AUTO_SET, 16'h0000);
    drain;
    $display("setting test done");
    close_out;
  end
endmodule
`default_nettype wire
